// [hw/serdes_lane_config_regs.sv]
// Notes on behaviour
// - precursor code: top bit sign, low three bits magnitude in 2.5 percent steps
// - second postcursor code 0111 is +17.5 percent, 1111 is -17.5 percent
// - lane select mask sits in config bits 15:12, one bit per lane, resets 1111
// - gated writes update every lane whose mask bit is set, others untouched
// - gated reads return the one lane named by a one-hot mask
// - loop bandwidth field 9:8 resets to 01; 10 with cleaner pll; 00, 11 reserved
// - gated lane registers live in device 1E; register 0007 resets DC04 per lane
`timescale 1ns/1ps
`default_nettype none
module serdes_lane_config_regs #(
    parameter logic [4:0] PORT_ADDR = 5'h00,
    parameter int         LANES     = 4
) (
    input  wire logic                 I_CLK,
    input  wire logic                 I_SYS_RST,
    input  wire logic                 i_mdc,
    input  wire logic                 i_mdio,
    output logic                      o_mdio,
    output logic                      o_mdio_oe_n,
    output logic [3:0]                o_fast_tx_precursor_weight,
    output logic [3:0]                o_fast_tx_second_postcursor_weight,
    output logic [1:0]                o_slow_side_pll_loop_bw,
    output logic [LANES-1:0]          o_slow_lane_select_mask,
    output logic [16*LANES-1:0]       o_slow_side_drive_config
);
    serdes_cfg_pkg::mdio_state_t state_r;
    logic                 mdc_q_r;
    logic                 rise;
    logic [5:0]           pre_cnt_r;
    logic [3:0]           cnt_r;
    logic [11:0]          hdr_r;
    logic [15:0]          sh_r;
    logic [15:0]          addr_r;
    logic                 hit_r;
    logic                 rd_r;
    logic [1:0]           op_r;
    logic                 wr_pulse;
    logic [15:0]          wr_data;
    logic [15:0]          fast_taps_r;
    logic [15:0]          slow_cfg_r;
    logic [15:0]          lane_r [LANES];
    logic [15:0]          rdata;
    logic [LANES-1:0]     mask;
    logic                 hdr_hit;

    // sign-magnitude tap code to two's complement in 2.5 percent units
    function automatic logic [3:0] tap_decode(input logic [3:0] code);
        logic [3:0] mag;
        mag = {1'b0, code[2:0]};
        tap_decode = code[3] ? 4'(-mag) : mag;
    endfunction

    assign rise    = i_mdc & ~mdc_q_r;
    assign mask    = slow_cfg_r[serdes_cfg_pkg::MASK_LSB +: LANES];
    assign hdr_hit = (hdr_r[8:4] == PORT_ADDR) &&
                     ({hdr_r[3:0], i_mdio} == serdes_cfg_pkg::MMD_ADDR);

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            mdc_q_r <= 1'b0;
        end else begin
            mdc_q_r <= i_mdc;
        end
    end

    // frame receiver and responder, all steps on rising edges of the management clock
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_r     <= serdes_cfg_pkg::S_PRE;
            pre_cnt_r   <= 6'h00;
            cnt_r       <= 4'h0;
            hdr_r       <= 12'h000;
            sh_r        <= 16'h0000;
            hit_r       <= 1'b0;
            rd_r        <= 1'b0;
            op_r        <= 2'h0;
            o_mdio      <= 1'b1;
            o_mdio_oe_n <= 1'b1;
        end else if (rise) begin
            case (state_r)
                serdes_cfg_pkg::S_PRE: begin
                    if (i_mdio) begin
                        if (pre_cnt_r != serdes_cfg_pkg::PREAMBLE_BITS) begin
                            pre_cnt_r <= pre_cnt_r + 6'h01;
                        end
                    end else if (pre_cnt_r == serdes_cfg_pkg::PREAMBLE_BITS) begin
                        state_r <= serdes_cfg_pkg::S_ST;
                    end else begin
                        pre_cnt_r <= 6'h00;
                    end
                end
                serdes_cfg_pkg::S_ST: begin
                    pre_cnt_r <= 6'h00;
                    cnt_r     <= 4'h0;
                    // only the extended-address start code is answered
                    state_r   <= i_mdio ? serdes_cfg_pkg::S_PRE : serdes_cfg_pkg::S_HDR;
                end
                serdes_cfg_pkg::S_HDR: begin
                    hdr_r <= {hdr_r[10:0], i_mdio};
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == serdes_cfg_pkg::HDR_BITS - 4'h1) begin
                        hit_r   <= hdr_hit;
                        op_r    <= hdr_r[10:9];
                        rd_r    <= hdr_r[10];
                        cnt_r   <= 4'h0;
                        state_r <= serdes_cfg_pkg::S_TA;
                    end
                end
                serdes_cfg_pkg::S_TA: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'h0) begin
                        if (rd_r && hit_r) begin
                            o_mdio      <= 1'b0;
                            o_mdio_oe_n <= 1'b0;
                        end
                    end else begin
                        cnt_r   <= 4'h0;
                        state_r <= serdes_cfg_pkg::S_DATA;
                        if (rd_r && hit_r) begin
                            o_mdio <= rdata[15];
                            sh_r   <= {rdata[14:0], 1'b0};
                        end
                    end
                end
                serdes_cfg_pkg::S_DATA: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (rd_r) begin
                        // a foreign read must not disturb the idle level of the line
                        if (hit_r) begin
                            o_mdio <= sh_r[15];
                        end
                        sh_r   <= {sh_r[14:0], 1'b0};
                    end else begin
                        sh_r <= {sh_r[14:0], i_mdio};
                    end
                    if (cnt_r == serdes_cfg_pkg::DATA_BITS) begin
                        o_mdio      <= 1'b1;
                        o_mdio_oe_n <= 1'b1;
                        state_r     <= serdes_cfg_pkg::S_PRE;
                    end
                end
                default: begin
                    state_r <= serdes_cfg_pkg::S_PRE;
                end
            endcase
        end
    end

    assign wr_pulse = rise && (state_r == serdes_cfg_pkg::S_DATA) && !rd_r && hit_r &&
                      (cnt_r == serdes_cfg_pkg::DATA_BITS);
    assign wr_data  = {sh_r[14:0], i_mdio};

    // address register; read-increment steps it once the word has gone out
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            addr_r <= 16'h0000;
        end else if (wr_pulse && op_r == serdes_cfg_pkg::OP_ADDRESS) begin
            addr_r <= wr_data;
        end else if (rise && hit_r && state_r == serdes_cfg_pkg::S_DATA &&
                     op_r == serdes_cfg_pkg::OP_READ_INC &&
                     cnt_r == serdes_cfg_pkg::DATA_BITS) begin
            addr_r <= addr_r + 16'h0001;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            fast_taps_r <= serdes_cfg_pkg::RST_FAST_TX_TAPS;
            slow_cfg_r  <= serdes_cfg_pkg::RST_SLOW_PLL_CFG;
        end else if (wr_pulse && op_r == serdes_cfg_pkg::OP_WRITE) begin
            // reserved bits are stored as written; keeping them zero is up to software
            if (addr_r == serdes_cfg_pkg::ADDR_FAST_TX_TAPS) begin
                fast_taps_r <= wr_data;
            end
            if (addr_r == serdes_cfg_pkg::ADDR_SLOW_PLL_CFG) begin
                slow_cfg_r <= wr_data;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
                if (I_SYS_RST) begin
                    lane_r[g] <= serdes_cfg_pkg::RST_SLOW_DRIVE_CFG;
                end else if (wr_pulse && op_r == serdes_cfg_pkg::OP_WRITE &&
                             addr_r == serdes_cfg_pkg::ADDR_SLOW_DRIVE_CFG && mask[g]) begin
                    lane_r[g] <= wr_data;
                end
            end
            always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
                if (I_SYS_RST) begin
                    o_slow_side_drive_config[16*g +: 16] <= serdes_cfg_pkg::RST_SLOW_DRIVE_CFG;
                end else begin
                    o_slow_side_drive_config[16*g +: 16] <= lane_r[g];
                end
            end
        end
    endgenerate

    // gated read: a non one-hot mask yields zero, which the host must ignore
    always_comb begin
        rdata = 16'h0000;
        case (addr_r)
            serdes_cfg_pkg::ADDR_FAST_TX_TAPS: rdata = fast_taps_r;
            serdes_cfg_pkg::ADDR_SLOW_PLL_CFG: rdata = slow_cfg_r;
            serdes_cfg_pkg::ADDR_SLOW_DRIVE_CFG: begin
                for (int i = 0; i < LANES; i++) begin
                    if (mask == LANES'(1 << i)) begin
                        rdata = lane_r[i];
                    end
                end
            end
            default: rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            o_fast_tx_precursor_weight         <= 4'h0;
            o_fast_tx_second_postcursor_weight <= 4'h0;
            o_slow_side_pll_loop_bw            <= serdes_cfg_pkg::LOOP_BW_NO_CLEANER;
            o_slow_lane_select_mask            <= {LANES{1'b1}};
        end else begin
            o_fast_tx_precursor_weight <=
                tap_decode(fast_taps_r[serdes_cfg_pkg::PRE_LSB +: 4]);
            o_fast_tx_second_postcursor_weight <=
                tap_decode(fast_taps_r[serdes_cfg_pkg::POST2_LSB +: 4]);
            o_slow_side_pll_loop_bw <= slow_cfg_r[serdes_cfg_pkg::LOOP_BW_LSB +: 2];
            o_slow_lane_select_mask <= mask;
        end
    end
endmodule
`default_nettype wire

// [hw/serdes_cfg_pkg.sv]
package serdes_cfg_pkg;
    // management device holding this bank
    localparam logic [4:0]  MMD_ADDR            = 5'h1E;
    // register addresses inside that device
    localparam logic [15:0] ADDR_FAST_TX_TAPS   = 16'h0005;
    localparam logic [15:0] ADDR_SLOW_PLL_CFG   = 16'h0006;
    localparam logic [15:0] ADDR_SLOW_DRIVE_CFG = 16'h0007;
    // reset values
    localparam logic [15:0] RST_FAST_TX_TAPS    = 16'h2000;
    localparam logic [15:0] RST_SLOW_PLL_CFG    = 16'hF115;
    localparam logic [15:0] RST_SLOW_DRIVE_CFG  = 16'hDC04;
    // field positions
    localparam int          PRE_LSB             = 4;
    localparam int          POST2_LSB           = 0;
    localparam int          MASK_LSB            = 12;
    localparam int          LOOP_BW_LSB         = 8;
    // loop bandwidth encodings
    localparam logic [1:0]  LOOP_BW_NO_CLEANER  = 2'h1;
    localparam logic [1:0]  LOOP_BW_CLEANER     = 2'h2;
    // management frame opcodes
    localparam logic [1:0]  OP_ADDRESS          = 2'h0;
    localparam logic [1:0]  OP_WRITE            = 2'h1;
    localparam logic [1:0]  OP_READ_INC         = 2'h2;
    localparam logic [1:0]  OP_READ             = 2'h3;
    // frame field lengths; data is given as its 16 bits less one, the last count value
    localparam logic [5:0]  PREAMBLE_BITS       = 6'h20;
    localparam logic [3:0]  HDR_BITS            = 4'hC;
    localparam logic [3:0]  DATA_BITS           = 4'hF;
    typedef enum {
        S_PRE,
        S_ST,
        S_HDR,
        S_TA,
        S_DATA
    } mdio_state_t;
endpackage

// [dv/serdes_lane_config_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module serdes_lane_config_regs_chk #(
    parameter int LANES = 4
) (
    input wire logic                I_CLK,
    input wire logic                I_SYS_RST,
    input wire logic                i_mdc,
    input wire logic                o_mdio,
    input wire logic                o_mdio_oe_n,
    input wire logic [3:0]          o_fast_tx_precursor_weight,
    input wire logic [3:0]          o_fast_tx_second_postcursor_weight,
    input wire logic [1:0]          o_slow_side_pll_loop_bw,
    input wire logic [LANES-1:0]    o_slow_lane_select_mask,
    input wire logic [16*LANES-1:0] o_slow_side_drive_config
);
    logic       mdc_prev_r;
    logic [4:0] rise_cnt_r;
    // mdc rises seen while the device owns the line
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            mdc_prev_r <= 1'b0;
            rise_cnt_r <= 5'h00;
        end else begin
            mdc_prev_r <= i_mdc;
            rise_cnt_r <= o_mdio_oe_n ? 5'h00 : rise_cnt_r + {4'h0, i_mdc && !mdc_prev_r};
        end
    end
    function automatic logic [16*LANES-1:0] spread(input logic [LANES-1:0] m);
        for (int n = 0; n < LANES; n++) spread[16*n+:16] = {16{m[n]}};
    endfunction
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    property p_rst_cfg; $fell(I_SYS_RST) |-> o_slow_lane_select_mask == {LANES{1'b1}}
        && o_slow_side_pll_loop_bw == 2'h1; endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("config wrong after reset");
    property p_rst_lanes; $fell(I_SYS_RST) |-> o_slow_side_drive_config == {LANES{16'hDC04}}
        && o_fast_tx_precursor_weight == 4'h0; endproperty
    a_rst_lanes: assert property (p_rst_lanes) else $error("lanes wrong after reset");
    property p_masked_hold; ((o_slow_side_drive_config ^ $past(o_slow_side_drive_config))
        & ~spread(o_slow_lane_select_mask)) == '0; endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("masked lane changed");
    property p_pre_range; o_fast_tx_precursor_weight != 4'h8; endproperty
    a_pre_range: assert property (p_pre_range) else $error("precursor out of range");
    property p_post2_range; o_fast_tx_second_postcursor_weight != 4'h8; endproperty
    a_post2_range: assert property (p_post2_range) else $error("postcursor out of range");
    property p_ta_low; $fell(o_mdio_oe_n) |-> !o_mdio; endproperty
    a_ta_low: assert property (p_ta_low) else $error("turnaround not low");
    property p_idle_high; o_mdio_oe_n |-> o_mdio; endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle data not high");
    property p_on_mdc; $changed(o_mdio) || $changed(o_mdio_oe_n) |-> $past(i_mdc); endproperty
    a_on_mdc: assert property (p_on_mdc) else $error("data moved without mdc");
    property p_window; $rose(o_mdio_oe_n) |-> rise_cnt_r == 5'h11; endproperty
    a_window: assert property (p_window) else $error("read window length wrong");
    c_read: cover property ($rose(o_mdio_oe_n));
    c_lane: cover property ($changed(o_slow_side_drive_config));
    c_bw: cover property ($changed(o_slow_side_pll_loop_bw));
endmodule
bind serdes_lane_config_regs serdes_lane_config_regs_chk #(.LANES(LANES)) chk_inst (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_mdc(i_mdc), .o_mdio(o_mdio),
    .o_mdio_oe_n(o_mdio_oe_n), .o_fast_tx_precursor_weight(o_fast_tx_precursor_weight),
    .o_fast_tx_second_postcursor_weight(o_fast_tx_second_postcursor_weight),
    .o_slow_side_pll_loop_bw(o_slow_side_pll_loop_bw),
    .o_slow_lane_select_mask(o_slow_lane_select_mask),
    .o_slow_side_drive_config(o_slow_side_drive_config));
`default_nettype wire

// [dv/mdio_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mdio_host_model (
    input  wire logic I_CLK,
    input  wire logic i_line,
    output var logic  o_mdc,
    output var logic  o_drv,
    output var logic  o_en
);
    initial begin
        o_mdc = 1'b0;
        o_drv = 1'b1;
        o_en  = 1'b0;
    end
    // mdc stands still between frames; reads release the line from turnaround on
    task automatic frame(input logic [1:0] op, input logic [4:0] dev,
                         input logic [15:0] din, output logic [15:0] dout);
        logic [63:0] bits;
        bits = {32'hFFFF_FFFF, 2'b00, op, 5'h00, dev, 2'b10, din};
        for (int i = 63; i >= 0; i--) begin
            @(posedge I_CLK);
            o_mdc <= 1'b0;
            o_en  <= !(op[1] && i < 18);
            o_drv <= bits[i];
            repeat (3) @(posedge I_CLK);
            dout = {dout[14:0], i_line};
            o_mdc <= 1'b1;
            repeat (2) @(posedge I_CLK);
        end
        o_mdc <= 1'b0;
        o_en  <= 1'b0;
        repeat (4) @(posedge I_CLK);
    endtask
endmodule
`default_nettype wire

// [dv/serdes_lane_config_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module serdes_lane_config_regs_test;
    logic        clk, rst, mdc, drv, en, line, mdo, oe_n;
    logic [3:0]  pre, post2, mask, m;
    logic [1:0]  bw;
    logic [63:0] lanes;
    logic [15:0] rd, v, taps, exp_lane [4];
    logic [16:0] lfsr_r = 17'h1038D;
    int          fails = 0, samples_checked = 0, cycles = 0;
    // pull-up on the shared data line
    assign line = !oe_n ? mdo : (en ? drv : 1'b1);
    serdes_lane_config_regs serdes_lane_config_regs_inst (.I_CLK(clk), .I_SYS_RST(rst),
        .i_mdc(mdc), .i_mdio(line), .o_mdio(mdo), .o_mdio_oe_n(oe_n),
        .o_fast_tx_precursor_weight(pre), .o_fast_tx_second_postcursor_weight(post2),
        .o_slow_side_pll_loop_bw(bw), .o_slow_lane_select_mask(mask),
        .o_slow_side_drive_config(lanes));
    mdio_host_model mdio_host_model_inst (.I_CLK(clk), .i_line(line), .o_mdc(mdc),
        .o_drv(drv), .o_en(en));
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic logic [3:0] tap(input logic [3:0] c);
        return c[3] ? 4'h0 - {1'b0, c[2:0]} : {1'b0, c[2:0]};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [1:0] op, input logic [15:0] d);
        mdio_host_model_inst.frame(op, 5'h1E, d, rd);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        xfer(serdes_cfg_pkg::OP_ADDRESS, a);
        xfer(serdes_cfg_pkg::OP_WRITE, d);
    endtask
    task automatic rd_reg(input logic [15:0] a);
        xfer(serdes_cfg_pkg::OP_ADDRESS, a);
        xfer(serdes_cfg_pkg::OP_READ, 16'h0000);
    endtask
    task automatic test_done;
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // about 60000 cycles expected
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        foreach (exp_lane[n]) exp_lane[n] = 16'hDC04;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(lanes, {4{16'hDC04}});
        check({mask, bw, pre, post2}, {4'hF, 2'h1, 8'h00});
        rd_reg(serdes_cfg_pkg::ADDR_SLOW_PLL_CFG);
        check(rd, 16'hF115);
        // every code of both tap fields, upper bits random
        for (int i = 0; i < 16; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            v = {lfsr_r[7:0], i[3:0], ~i[3:0]};
            taps = v;
            wr(serdes_cfg_pkg::ADDR_FAST_TX_TAPS, v);
            check(pre, tap(i[3:0]));
            check(post2, tap(~i[3:0]));
        end
        for (int k = 0; k < 5; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            m = (k == 0) ? 4'h3 : lfsr_r[3:0];
            v = lfsr_r[16:1];
            // reserved bits 11:10 kept at zero
            wr(serdes_cfg_pkg::ADDR_SLOW_PLL_CFG, {m, 4'h2, 8'h15});
            check({mask, bw}, {m, 2'h2});
            wr(serdes_cfg_pkg::ADDR_SLOW_DRIVE_CFG, v);
            for (int n = 0; n < 4; n++) if (m[n]) exp_lane[n] = v;
            check(lanes, {exp_lane[3], exp_lane[2], exp_lane[1], exp_lane[0]});
            for (int n = 0; n < 4; n++) begin
                wr(serdes_cfg_pkg::ADDR_SLOW_PLL_CFG, {4'h1 << n, 4'h1, 8'h15});
                rd_reg(serdes_cfg_pkg::ADDR_SLOW_DRIVE_CFG);
                check(rd, exp_lane[n]);
            end
        end
        // read with all lanes selected: data checked to read zero
        wr(serdes_cfg_pkg::ADDR_SLOW_PLL_CFG, 16'hF115);
        rd_reg(serdes_cfg_pkg::ADDR_SLOW_DRIVE_CFG);
        check(rd, 16'h0000);
        // foreign device address: no drive, no write
        mdio_host_model_inst.frame(serdes_cfg_pkg::OP_WRITE, 5'h1F, 16'h0000, rd);
        mdio_host_model_inst.frame(serdes_cfg_pkg::OP_READ, 5'h1F, 16'h0000, rd);
        check(rd, 16'hFFFF);
        check(lanes, {exp_lane[3], exp_lane[2], exp_lane[1], exp_lane[0]});
        xfer(serdes_cfg_pkg::OP_ADDRESS, serdes_cfg_pkg::ADDR_FAST_TX_TAPS);
        xfer(serdes_cfg_pkg::OP_READ_INC, 16'h0000);
        check(rd, taps);
        xfer(serdes_cfg_pkg::OP_READ, 16'h0000);
        check(rd, 16'hF115);
        rd_reg(16'h0008);
        check(rd, 16'h0000);
        // second reset in mid-run: everything back to its reset value
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(lanes, {4{16'hDC04}});
        check({mask, bw, pre, post2}, {4'hF, 2'h1, 8'h00});
        rd_reg(serdes_cfg_pkg::ADDR_FAST_TX_TAPS);
        check(rd, 16'h2000);
        test_done();
    end
endmodule
`default_nettype wire
